// *** hw/trip_latch_cfg.svh ***
// Purpose: constants for the motor trip latch and indicator block
// Assumes: core_clk at 200 MHz
// Notes: register map on classic Wishbone, 32-bit words
//
// How it works
// (RULE1) trips stay latched until fieldbus reset
// (RULE2) auto reset off: only controller acknowledge clears
// (RULE3) auto reset on: clear once cause gone (code: overload, phase-loss and unbalance trips only)
// (RULE4) no fault history kept anywhere
// (RULE5) red indicator on while trip latched (code: double flash instead while bus supply low)
// (RULE6) latched trip sets its status bit
// (RULE7) phase current low raises phase-loss trip
// (RULE8) self-test fault trips, separate module flags
// (RULE9) missing sensor module raises a trip
// (RULE10) out-of-range parameter write raises trip
// (RULE11) low control voltage flagged, no trip
// (RULE12) overload trip: cooling shown, restart after
// (RULE13) line frequency undetected is indicated
// (RULE14) red double flash on low bus supply
// (RULE15) persisting cause keeps trip latched after reset
`ifndef TRIP_LATCH_CFG_SVH
`define TRIP_LATCH_CFG_SVH

`define ADR_CTRL      4'h0
`define ADR_STATUS    4'h1
`define ADR_CMD       4'h2
`define ADR_COOL      4'h3

`define CTRL_AUTO_BIT 0
`define CTRL_RUN_BIT  1
`define CMD_RESET_BIT 0

`define TRIP_OVERLOAD 0
`define TRIP_PHLOSS   1
`define TRIP_UNBAL    2
`define TRIP_FMHW     3
`define TRIP_SMHW     4
`define TRIP_SMMISS   5
`define TRIP_PARAM    6
`define TRIP_COUNT    7

`define ST_COOL_BIT   8
`define ST_VLOW_BIT   9
`define ST_FREQ_BIT   10
`define ST_RUN_BIT    11

`define COOL_DEF      32'h0000_03e8
`define FLASH_PERIOD_NS  1000000
`define CLK_PERIOD_NS    5
`define FLASH_DIV     (`FLASH_PERIOD_NS / `CLK_PERIOD_NS)
`define DFLASH_STEPS  4'ha

`endif

// *** hw/trip_latch_pkg.sv ***
// Purpose: types for the motor trip latch block
// Assumes: nothing
// Notes: one state enum for the red pattern
package trip_latch_pkg;
  typedef enum logic [1:0] {
    RED_OFF,
    RED_ON,
    RED_DFLASH
  } red_mode_t;
endpackage : trip_latch_pkg

// *** hw/motor_trip_latch_indicator.sv ***
// Purpose: trip latching, auto reset, cooling and LED drive
// Assumes: trip causes from measurement logic, same clock except pins
// Notes: no history store; registers on classic Wishbone
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`include "trip_latch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_trip_latch_indicator #(
  parameter int unsigned FLASH_DIV = `FLASH_DIV
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [5:2]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              fieldbus_reset_cmd,
  input  wire logic              thermal_overload_det,
  input  wire logic [2:0]        phase_below_thresh,
  input  wire logic              unbalance_det,
  input  wire logic              function_module_hw_fault_det,
  input  wire logic              sensor_module_hw_fault_det,
  input  wire logic              sensor_module_missing_pin,
  input  wire logic              param_write_strobe,
  input  wire logic              param_out_of_limits,
  input  wire logic              ctrl_voltage_low_pin,
  input  wire logic              line_freq_lost,
  input  wire logic              bus_supply_low_pin,
  output logic [`TRIP_COUNT-1:0] trip_status,
  output logic                   function_module_hw_fault_flag,
  output logic                   sensor_module_hw_fault_flag,
  output logic                   cooling_running,
  output logic                   restart_permit,
  output logic                   ctrl_voltage_low_flag,
  output logic                   line_freq_flag,
  output logic                   red_led,
  output logic                   green_led
);
  import trip_latch_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {bus_supply_low_pin, ctrl_voltage_low_pin, sensor_module_missing_pin};
      sync2_ff <= sync1_ff;
    end
  end

  wire logic smiss_s = sync2_ff[0];
  wire logic vlow_s  = sync2_ff[1];
  wire logic bus_s   = sync2_ff[2];

  // ----------------------------------------
  // wishbone registers
  // ----------------------------------------
  logic        auto_reset_ff;
  logic        run_ff;
  logic        sw_reset_ff;
  logic [31:0] cool_len_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;

  wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic bus_wr  = bus_req && wb_we_i;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_reset_ff <= 1'b0; // RULE2
      run_ff        <= 1'b0;
      cool_len_ff   <= `COOL_DEF;
    end else if (bus_wr && wb_adr_i == `ADR_CTRL && wb_sel_i[0]) begin
      auto_reset_ff <= wb_dat_i[`CTRL_AUTO_BIT];
      run_ff        <= wb_dat_i[`CTRL_RUN_BIT];
    end else if (bus_wr && wb_adr_i == `ADR_COOL) begin
      cool_len_ff   <= merge_sel(cool_len_ff, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_reset_ff <= 1'b0;
    end else begin
      sw_reset_ff <= bus_wr && wb_adr_i == `ADR_CMD && wb_sel_i[0] && wb_dat_i[`CMD_RESET_BIT];
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[`TRIP_COUNT-1:0] = trip_status;
    status_word[`ST_COOL_BIT] = cooling_running;
    status_word[`ST_VLOW_BIT] = ctrl_voltage_low_flag;
    status_word[`ST_FREQ_BIT] = line_freq_flag;
    status_word[`ST_RUN_BIT]  = run_ff;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        case (wb_adr_i)
          `ADR_CTRL:   rdat_ff <= {30'h0, run_ff, auto_reset_ff};
          `ADR_STATUS: rdat_ff <= status_word;
          `ADR_COOL:   rdat_ff <= cool_len_ff;
          default:     rdat_ff <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------
  // trip latches
  // ----------------------------------------
  logic [`TRIP_COUNT-1:0] cause;
  logic [`TRIP_COUNT-1:0] auto_mask;
  logic                   ack_any;
  logic [`TRIP_COUNT-1:0] trip_ff;

  always_comb begin
    cause = '0;
    cause[`TRIP_OVERLOAD] = thermal_overload_det || cooling_running;
    cause[`TRIP_PHLOSS]   = |phase_below_thresh; // RULE7
    cause[`TRIP_UNBAL]    = unbalance_det;
    cause[`TRIP_FMHW]     = function_module_hw_fault_det; // RULE8
    cause[`TRIP_SMHW]     = sensor_module_hw_fault_det; // RULE8
    cause[`TRIP_SMMISS]   = smiss_s; // RULE9
    cause[`TRIP_PARAM]    = param_write_strobe && param_out_of_limits; // RULE10
    auto_mask = '0;
    auto_mask[`TRIP_OVERLOAD] = 1'b1;
    auto_mask[`TRIP_PHLOSS]   = 1'b1;
    auto_mask[`TRIP_UNBAL]    = 1'b1;
  end

  assign ack_any = fieldbus_reset_cmd || sw_reset_ff; // RULE2

  // set wins over clear; no history beyond present latches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trip_ff <= '0;
    end else begin
      for (int i = 0; i < `TRIP_COUNT; i++) begin
        if (cause[i]) begin
          trip_ff[i] <= 1'b1; // RULE1 RULE15
        end else if (ack_any) begin
          trip_ff[i] <= 1'b0; // RULE2
        end else if (auto_reset_ff && auto_mask[i]) begin
          trip_ff[i] <= 1'b0; // RULE3
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trip_status                   <= '0;
      function_module_hw_fault_flag <= 1'b0;
      sensor_module_hw_fault_flag   <= 1'b0;
      ctrl_voltage_low_flag         <= 1'b0;
      line_freq_flag                <= 1'b0;
    end else begin
      trip_status                   <= trip_ff; // RULE6 RULE4
      function_module_hw_fault_flag <= trip_ff[`TRIP_FMHW]; // RULE8
      sensor_module_hw_fault_flag   <= trip_ff[`TRIP_SMHW]; // RULE8
      ctrl_voltage_low_flag         <= vlow_s; // RULE11
      line_freq_flag                <= line_freq_lost; // RULE13
    end
  end

  // ----------------------------------------
  // cooling time
  // ----------------------------------------
  logic [31:0] cool_cnt_ff;
  logic        tick;
  logic [31:0] div_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_ff <= 32'h0;
      tick   <= 1'b0;
    end else if (div_ff == 32'(FLASH_DIV - 1)) begin
      div_ff <= 32'h0;
      tick   <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h1;
      tick   <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cool_cnt_ff <= 32'h0;
    end else if (thermal_overload_det) begin
      cool_cnt_ff <= cool_len_ff; // RULE12
    end else if (tick && cool_cnt_ff != 32'h0) begin
      cool_cnt_ff <= cool_cnt_ff - 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cooling_running <= 1'b0;
      restart_permit  <= 1'b0;
    end else begin
      cooling_running <= cool_cnt_ff != 32'h0; // RULE12
      restart_permit  <= ~|trip_ff && cool_cnt_ff == 32'h0; // RULE12
    end
  end

  // ----------------------------------------
  // led patterns
  // ----------------------------------------
  red_mode_t red_mode;
  logic [3:0] step_ff;

  always_comb begin
    if (bus_s) begin
      red_mode = RED_DFLASH; // RULE14
    end else if (|trip_ff) begin
      red_mode = RED_ON; // RULE5
    end else begin
      red_mode = RED_OFF; // RULE14
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_ff <= 4'h0;
    end else if (tick) begin
      step_ff <= (step_ff == `DFLASH_STEPS - 4'h1) ? 4'h0 : step_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      red_led   <= 1'b0;
      green_led <= 1'b0;
    end else begin
      green_led <= run_ff;
      case (red_mode)
        RED_OFF:    red_led <= 1'b0;
        RED_ON:     red_led <= 1'b1; // RULE5
        RED_DFLASH: red_led <= (step_ff == 4'h0) || (step_ff == 4'h2); // RULE14
        default:    red_led <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_latch_holds: assert property (trip_ff[`TRIP_FMHW] && !ack_any |=> trip_ff[`TRIP_FMHW]) // RULE1
    else $error("trip dropped without reset");
  chk_manual_only: assert property (!auto_reset_ff && trip_ff[`TRIP_PHLOSS] && !ack_any |=> trip_ff[`TRIP_PHLOSS]) // RULE2
    else $error("trip cleared without acknowledge");
  chk_auto_clear: assert property (auto_reset_ff && trip_ff[`TRIP_UNBAL] && !cause[`TRIP_UNBAL] |=> !trip_ff[`TRIP_UNBAL]) // RULE3
    else $error("auto reset did not clear");
  chk_red_on: assert property (!bus_s && |trip_ff |=> red_led) // RULE5
    else $error("red off with trip");
  chk_status_bit: assert property (trip_ff[`TRIP_PARAM] |=> trip_status[`TRIP_PARAM]) // RULE6
    else $error("status bit missing");
  chk_phase_loss: assert property (|phase_below_thresh |=> trip_ff[`TRIP_PHLOSS]) // RULE7
    else $error("phase loss not tripped");
  chk_miss_trip: assert property ($rose(smiss_s) |=> trip_ff[`TRIP_SMMISS]) // RULE9
    else $error("missing module not tripped");
  chk_vlow_flag: assert property (vlow_s |=> ctrl_voltage_low_flag) // RULE11
    else $error("low voltage not flagged");
  chk_cool_restart: assert property (cooling_running |-> !restart_permit) // RULE12
    else $error("restart during cooling");
  chk_reset_persist: assert property (ack_any && cause[`TRIP_SMHW] |=> trip_ff[`TRIP_SMHW]) // RULE15
    else $error("persisting trip cleared");
  chk_red_idle: assert property (!bus_s && !(|trip_ff) |=> !red_led) // RULE14
    else $error("red on without fault");

  cov_manual_ack: cover property (trip_ff[`TRIP_PHLOSS] ##1 ack_any ##1 !trip_ff[`TRIP_PHLOSS]);
  cov_auto_clear: cover property (auto_reset_ff && $fell(trip_ff[`TRIP_UNBAL]));
  cov_cooling:    cover property ($rose(cooling_running));
  cov_dflash:     cover property (red_mode == RED_DFLASH && red_led);

endmodule : motor_trip_latch_indicator

`default_nettype wire

// *** tb/plc_partner.sv ***
// Purpose: controller model issuing fault reset over fieldbus
// Assumes: same clock as the block
// Notes: slow mode waits three cycles before the command
`timescale 1ns/1ps
`default_nettype none

module plc_partner (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ack_req,
  input  wire logic slow,
  output logic      reset_cmd
);
  logic [1:0] wait_ff;
  logic       pend_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_ff   <= 1'b0;
      wait_ff   <= 2'h0;
      reset_cmd <= 1'b0;
    end else begin
      reset_cmd <= 1'b0;
      if (ack_req) begin
        pend_ff <= 1'b1;
        wait_ff <= slow ? 2'h3 : 2'h0;
      end else if (pend_ff && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else if (pend_ff) begin
        pend_ff   <= 1'b0;
        reset_cmd <= 1'b1;
      end
    end
  end
endmodule : plc_partner

`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the trip latch block
// Assumes: FLASH_DIV set to 4
// Notes: trip model kept in m_trip
`include "trip_latch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  import trip_latch_pkg::*;
  logic core_clk, rst, cyc, stb, we, preq, slow, fcmd, thd, unb, fmhw, smhw, smmiss, pws, pool, cvl, lfl, bsl;
  logic [3:0]  adr;
  logic [2:0]  ph;
  logic [31:0] dat, rdat, q;
  logic [6:0]  trips;
  logic        ack, fmf, smf, cool, rperm, cvf, lff, red, green;
  int          miscompares, check_count, seed, m_trip, n;

  motor_trip_latch_indicator #(.FLASH_DIV(4)) motor_trip_latch_indicator_inst (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .fieldbus_reset_cmd(fcmd),
    .thermal_overload_det(thd), .phase_below_thresh(ph), .unbalance_det(unb),
    .function_module_hw_fault_det(fmhw), .sensor_module_hw_fault_det(smhw),
    .sensor_module_missing_pin(smmiss), .param_write_strobe(pws), .param_out_of_limits(pool),
    .ctrl_voltage_low_pin(cvl), .line_freq_lost(lfl), .bus_supply_low_pin(bsl), .trip_status(trips),
    .function_module_hw_fault_flag(fmf), .sensor_module_hw_fault_flag(smf), .cooling_running(cool),
    .restart_permit(rperm), .ctrl_voltage_low_flag(cvf), .line_freq_flag(lff), .red_led(red),
    .green_led(green));

  plc_partner plc_partner_inst (.core_clk(core_clk), .rst(rst), .ack_req(preq), .slow(slow), .reset_cmd(fcmd));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic cyc_n(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc_n

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      cmp("wb_ack_o", 32'h1, 32'h0);
      close_out();
    end
  endtask : wb

  task automatic chk(input logic [6:0] e);
    wb(1'b0, `ADR_STATUS, 32'h0);
    cmp("trip_status", 32'(e), 32'(trips));
    cmp("status_trips", 32'(e), 32'(q[6:0]));
    cmp("red_led", 32'(|e), 32'(red));
    cmp("fm_hw_flag", 32'(e[3]), 32'(fmf));
    cmp("sm_hw_flag", 32'(e[4]), 32'(smf));
  endtask : chk

  task automatic ack_trips(input logic via_bus);
    if (via_bus) wb(1'b1, `ADR_CMD, 32'h1);
    else begin
      @(posedge core_clk);
      preq <= 1'b1;
      slow <= 1'($random(seed));
      @(posedge core_clk);
      preq <= 1'b0;
    end
    cyc_n(8);
  endtask : ack_trips

  task automatic drive(input int i, input logic v);
    case (i)
      1: ph <= v ? 3'(({$random(seed)} % 7) + 1) : 3'h0;
      2: unb <= v;
      3: fmhw <= v;
      4: smhw <= v;
      5: smmiss <= v;
      default: begin
        pws  <= v;
        pool <= v;
      end
    endcase
  endtask : drive

  initial begin
    seed = 32'h53aa9a33;
    {cyc, stb, we, preq, slow, thd, unb, fmhw, smhw, smmiss, pws, pool, cvl, lfl, bsl} = '0;
    adr = 4'h0;
    dat = 32'h0;
    ph = 3'h0;
    rst = 1'b1;
    cyc_n(16);
    rst <= 1'b0;
    cyc_n(1);
    chk(7'h0);
    wb(1'b0, `ADR_CTRL, 32'h0);
    cmp("ctrl_reset", 32'h0, q);
    wb(1'b0, `ADR_COOL, 32'h0);
    cmp("cool_reset", `COOL_DEF, q);
    wb(1'b1, 4'hf, 32'($random(seed)));
    wb(1'b0, 4'hf, 32'h0);
    cmp("unmapped", 32'h0, q);
    pws <= 1'b1;
    cyc_n(3);
    pws <= 1'b0;
    cyc_n(4);
    chk(7'h0);
    $display("test reset done");
    for (int i = 1; i < 7; i++) begin
      drive(i, 1'b1);
      m_trip = 1 << i;
      cyc_n(6);
      chk(7'(m_trip));
      ack_trips(i[0]);
      chk(7'(m_trip));
      drive(i, 1'b0);
      cyc_n(6);
      chk(7'(m_trip));
      ack_trips(~i[0]);
      m_trip = 0;
      chk(7'(m_trip));
    end
    $display("test latch done");
    wb(1'b1, `ADR_CTRL, 32'h1);
    for (int i = 1; i < 4; i++) begin
      drive(i, 1'b1);
      cyc_n(3);
      drive(i, 1'b0);
      m_trip = (i == 3) ? 8 : 0;
      cyc_n(8);
      chk(7'(m_trip));
    end
    ack_trips(1'b1);
    $display("test auto reset done");
    wb(1'b1, `ADR_CTRL, 32'h2);
    cyc_n(1);
    cmp("green_led", 32'h1, 32'(green));
    wb(1'b1, `ADR_COOL, 32'h5);
    thd <= 1'b1;
    cyc_n(2);
    thd <= 1'b0;
    cyc_n(4);
    chk(7'h1);
    cmp("cooling_running", 32'h1, 32'(cool));
    cmp("restart_permit", 32'h0, 32'(rperm));
    ack_trips(1'b0);
    chk(7'h1);
    cyc_n(40);
    cmp("cooling_running", 32'h0, 32'(cool));
    ack_trips(1'b1);
    chk(7'h0);
    cmp("restart_permit", 32'h1, 32'(rperm));
    $display("test cooling done");
    cvl <= 1'b1;
    lfl <= 1'b1;
    cyc_n(6);
    chk(7'h0);
    cmp("status_flags", 32'he, 32'(q[11:8]));
    cmp("ctrl_voltage_low_flag", 32'h1, 32'(cvf));
    cmp("line_freq_flag", 32'h1, 32'(lff));
    bsl <= 1'b1;
    cvl <= 1'b0;
    lfl <= 1'b0;
    cyc_n(8);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      n += (red === 1'b1);
    end
    cmp("red_flash_cycles", 32'h8, 32'(n));
    bsl <= 1'b0;
    cyc_n(8);
    cmp("red_led_off", 32'h0, 32'(red));
    cmp("line_freq_flag_off", 32'h0, 32'(lff));
    $display("test indication done");
    close_out();
  end
endmodule : tb

`default_nettype wire
